// >>> verilog/hpsc_pkg.sv
// constants, command codes and carriers of the hub port status/control word bank
package hpsc_pkg;

    localparam int NUM_CH              = 4;          // downstream channels
    localparam int CLK_FREQ_HZ         = 25_000_000; // ref_clk_in rate
    localparam int PORT_CYCLE_OFF_MS   = 100;        // bus power off time of a port cycle
    localparam int PORT_CYCLE_OFF_CYC  = PORT_CYCLE_OFF_MS * (CLK_FREQ_HZ / 1000);

    // bulk enable word: bit 2n data, bit 2n+1 power, bits 8 and up reserved
    localparam int BULK_FIELD_W        = 8;
    localparam int BULK_DATA_OFS       = 0;
    localparam int BULK_PWR_OFS        = 1;
    localparam logic [7:0] BULK_RESET  = 8'hFF;      // all channels up after reset

    // channel state word fields
    localparam int STATE_PWR_BIT       = 0;
    localparam int STATE_DATA_BIT      = 1;
    localparam int STATE_ERR_BIT       = 19;
    localparam int STATE_BOOST_BIT     = 20;
    localparam int STATE_ATTACH_BIT    = 23;
    localparam int STATE_CC_BIT        = 24;

    // channel error word fields
    localparam int ERR_CURLIM_BIT      = 0;
    localparam int ERR_BACKDRIVE_BIT   = 1;
    localparam int ERR_OVERTEMP_BIT    = 3;

    // upstream selection codes
    localparam logic [31:0] UPSTREAM_PORT0 = 32'h0000_0000;
    localparam logic [31:0] UPSTREAM_PORT1 = 32'h0000_0001;
    localparam logic [31:0] UPSTREAM_NONE  = 32'h0000_0002;

    // host commands
    typedef enum logic [2:0] {
        CMD_WRITE_BULK_PORT_ENABLES,
        CMD_READ_BULK_PORT_ENABLES,
        CMD_READ_CHANNEL_STATE,
        CMD_READ_CHANNEL_ERRORS,
        CMD_CLEAR_CHANNEL_ERRORS,
        CMD_READ_UPSTREAM_SELECTION,
        CMD_READ_SUBSYSTEM_TEMPERATURE
    } hpsc_op_type;

    // one request from the control path
    typedef struct packed {
        hpsc_op_type op;     // command
        logic [1:0]  chan;   // channel index 0..3
        logic [31:0] wdata;  // word for the bulk write
    } hpsc_cmd_type;

    // one answer
    typedef struct packed {
        logic        valid;  // one-cycle answer strobe
        logic [31:0] data;   // read word, zero for writes and clears
    } hpsc_rsp_type;

endpackage

// >>> verilog/hpsc_cycle_timer.sv
// hold-off timer that keeps a channel's bus power down during a port cycle
`timescale 1ns/100ps
`default_nettype none
module hpsc_cycle_timer #(
    parameter int CYCLES = hpsc_pkg::PORT_CYCLE_OFF_CYC
) (
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    input  wire logic start_in,   // (re)start the off interval
    output logic      busy_out    // high for CYCLES cycles after start
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_r;   // cycles left
    logic [CW-1:0] cnt_nxt;

    // a restart while busy stretches the interval instead of ending it early
    always_comb begin
        cnt_nxt = cnt_r;
        if (start_in) begin
            cnt_nxt = CW'(CYCLES);
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    // counter register
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign busy_out = (cnt_r != '0);
endmodule
`default_nettype wire

// >>> verilog/hpsc_chan_err.sv
// per-channel sticky error flags and trip latch
`timescale 1ns/100ps
`default_nettype none
module hpsc_chan_err (
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    input  wire logic clear_in,      // clear command for this channel
    input  wire logic curlim_in,     // current limit exceeded event
    input  wire logic backdrive_in,  // back-drive event
    input  wire logic trip_in,       // trip-off after limiting failed
    output logic      curlim_out,    // sticky flag
    output logic      backdrive_out, // sticky flag
    output logic      tripped_out    // channel held off
);
    import hpsc_pkg::*;

    logic curlim_r, curlim_nxt;
    logic backdrive_r, backdrive_nxt;
    logic tripped_r, tripped_nxt;

    // set wins over clear so an event in the clear cycle survives
    always_comb begin
        curlim_nxt    = (curlim_r    & ~clear_in) | curlim_in;
        backdrive_nxt = (backdrive_r & ~clear_in) | backdrive_in;
        tripped_nxt   = (tripped_r   & ~clear_in) | trip_in;
    end

    // flag registers
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            curlim_r    <= 1'b0;
            backdrive_r <= 1'b0;
            tripped_r   <= 1'b0;
        end else begin
            curlim_r    <= curlim_nxt;
            backdrive_r <= backdrive_nxt;
            tripped_r   <= tripped_nxt;
        end
    end

    assign curlim_out    = curlim_r;
    assign backdrive_out = backdrive_r;
    assign tripped_out   = tripped_r;

    a_curlim_sticky: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        curlim_in |=> curlim_r)
        else $error("current limit event not latched");
    a_clear_flags: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (clear_in && !curlim_in && !backdrive_in) |=> (!curlim_r && !backdrive_r))
        else $error("clear left port error flags set");
endmodule
`default_nettype wire

// >>> verilog/hpsc_word_bank.sv
// command-driven status and control word bank of the four-channel hub
`timescale 1ns/100ps
`default_nettype none
module hpsc_word_bank #(
    parameter int CYCLE_OFF_CYCLES = hpsc_pkg::PORT_CYCLE_OFF_CYC
) (
    input  wire logic                   ref_clk_in,
    input  wire logic                   rst_b_in,
    input  wire logic                   cmd_valid_in,         // request strobe
    input  wire hpsc_pkg::hpsc_cmd_type cmd_in,               // request contents
    output logic                        cmd_ready_out,        // always accepting
    output hpsc_pkg::hpsc_rsp_type      rsp_out,              // registered answer
    input  wire logic [3:0]             ch_curlim_in,         // limit exceeded events
    input  wire logic [3:0]             ch_backdrive_in,      // back-drive events
    input  wire logic [3:0]             ch_trip_in,           // trip-off events
    input  wire logic [3:0]             ch_attached_in,       // device attached levels
    input  wire logic [3:0]             ch_const_current_in,  // constant-current levels
    input  wire logic                   boost_enabled_in,     // downstream boost active
    input  wire logic                   hub_overtemp_in,      // hub overtemperature level
    input  wire logic                   up0_selected_in,      // upstream 0 is data path
    input  wire logic                   up1_selected_in,      // upstream 1 is data path
    input  wire logic [31:0]            temp_micro_c_in,      // signed micro-degrees C
    output logic [3:0]                  ch_data_en_out,       // hi-speed data switches
    output logic [3:0]                  ch_power_en_out       // bus power switches
);
    import hpsc_pkg::*;

    // requested enables as written by software
    logic [BULK_FIELD_W-1:0] bulk_r;
    logic [BULK_FIELD_W-1:0] bulk_nxt;

    // answer register
    hpsc_rsp_type rsp_r;
    hpsc_rsp_type rsp_nxt;

    // channel enable outputs, registered
    logic [3:0] data_en_r, data_en_nxt;
    logic [3:0] power_en_r, power_en_nxt;

    // per-channel helpers
    logic [3:0] req_data;       // data enable wanted
    logic [3:0] req_power;      // power enable wanted
    logic [3:0] new_data;       // data field of a bulk write
    logic [3:0] new_power;      // power field of a bulk write
    logic [3:0] clear_ch;       // clear strobe per channel
    logic [3:0] cycle_start;    // port cycle trigger per channel
    logic [3:0] cycling;        // power held off by a port cycle
    logic [3:0] err_curlim;     // sticky limit flag
    logic [3:0] err_backdrive;  // sticky back-drive flag
    logic [3:0] tripped;        // channel tripped off
    logic       overtemp_r;     // global hub overtemperature
    logic       overtemp_nxt;   // next overtemperature copy

    logic is_write;             // bulk write taken this cycle
    logic is_clear;             // clear taken this cycle

    assign cmd_ready_out = 1'b1;
    assign is_write = cmd_valid_in && (cmd_in.op == CMD_WRITE_BULK_PORT_ENABLES);
    assign is_clear = cmd_valid_in && (cmd_in.op == CMD_CLEAR_CHANNEL_ERRORS);

    // split the packed bulk field into per-channel wants
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign req_data[g]  = bulk_r[2*g + BULK_DATA_OFS];
            assign req_power[g] = bulk_r[2*g + BULK_PWR_OFS];
            assign new_data[g]  = cmd_in.wdata[2*g + BULK_DATA_OFS];
            assign new_power[g] = cmd_in.wdata[2*g + BULK_PWR_OFS];
            assign clear_ch[g]  = is_clear && (cmd_in.chan == 2'(g));

            // power stays on across the write but data flips: cycle power
            assign cycle_start[g] = is_write && req_power[g] && new_power[g]
                                    && (req_data[g] != new_data[g]);

            hpsc_cycle_timer #(
                .CYCLES (CYCLE_OFF_CYCLES)
            ) u_cycle (
                .ref_clk_in (ref_clk_in),
                .rst_b_in   (rst_b_in),
                .start_in   (cycle_start[g]),
                .busy_out   (cycling[g])
            );

            hpsc_chan_err u_err (
                .ref_clk_in    (ref_clk_in),
                .rst_b_in      (rst_b_in),
                .clear_in      (clear_ch[g]),
                .curlim_in     (ch_curlim_in[g]),
                .backdrive_in  (ch_backdrive_in[g]),
                .trip_in       (ch_trip_in[g]),
                .curlim_out    (err_curlim[g]),
                .backdrive_out (err_backdrive[g]),
                .tripped_out   (tripped[g])
            );

            a_cycle_power_off: assert property (@(posedge ref_clk_in)
                disable iff (!rst_b_in)
                cycle_start[g] |=> ##1 !ch_power_en_out[g])
                else $error("power not dropped for port cycle");
            a_trip_disables: assert property (@(posedge ref_clk_in)
                disable iff (!rst_b_in)
                ch_trip_in[g] |=> ##1 (!ch_power_en_out[g] && !ch_data_en_out[g]))
                else $error("tripped channel still enabled");
            a_trip_held: assert property (@(posedge ref_clk_in)
                disable iff (!rst_b_in)
                tripped[g] |=> (!ch_power_en_out[g] && !ch_data_en_out[g]))
                else $error("channel enabled while tripped");
            a_cycle_held: assert property (@(posedge ref_clk_in)
                disable iff (!rst_b_in)
                cycling[g] |=> !ch_power_en_out[g])
                else $error("power back on during port cycle");
            a_data_follows: assert property (@(posedge ref_clk_in)
                disable iff (!rst_b_in)
                !tripped[g] |=> (ch_data_en_out[g] == $past(req_data[g])))
                else $error("data switch disagrees with bulk word");
            a_clear_scope: assert property (@(posedge ref_clk_in)
                disable iff (!rst_b_in)
                (is_clear && cmd_in.chan != 2'(g) && err_backdrive[g]) |=> err_backdrive[g])
                else $error("clear reached another channel");
        end
    endgenerate

    // bulk word: only the eight enable bits are stored, the rest is dropped
    always_comb begin
        bulk_nxt = bulk_r;
        if (is_write) begin
            bulk_nxt = cmd_in.wdata[BULK_FIELD_W-1:0];
        end
    end

    // switch drive: a trip forces both off until cleared, a cycle only power
    always_comb begin
        data_en_nxt  = req_data & ~tripped;
        power_en_nxt = req_power & ~tripped & ~cycling;
    end

    // overtemp is a live copy; no command path reaches this register
    always_comb begin
        overtemp_nxt = hub_overtemp_in;
    end

    // state word of one channel, reserved bits zero
    function automatic logic [31:0] state_word(input logic [1:0] ch);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[STATE_PWR_BIT]    = power_en_r[ch];
        w[STATE_DATA_BIT]   = data_en_r[ch];
        w[STATE_ERR_BIT]    = tripped[ch] | err_curlim[ch] | err_backdrive[ch];
        w[STATE_BOOST_BIT]  = boost_enabled_in;
        w[STATE_ATTACH_BIT] = ch_attached_in[ch];
        w[STATE_CC_BIT]     = ch_const_current_in[ch];
        return w;
    endfunction

    // error word of one channel; overtemp is shared by all channels
    function automatic logic [31:0] error_word(input logic [1:0] ch);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ERR_CURLIM_BIT]    = err_curlim[ch];
        w[ERR_BACKDRIVE_BIT] = err_backdrive[ch];
        w[ERR_OVERTEMP_BIT]  = overtemp_r;
        return w;
    endfunction

    // upstream code: port 0 wins if both claim the path
    function automatic logic [31:0] upstream_word();
        logic [31:0] w;
        w = UPSTREAM_NONE;
        if (up0_selected_in) begin
            w = UPSTREAM_PORT0;
        end else if (up1_selected_in) begin
            w = UPSTREAM_PORT1;
        end
        return w;
    endfunction

    // answer for the command taken this cycle
    always_comb begin
        rsp_nxt.valid = cmd_valid_in;
        rsp_nxt.data  = 32'h0000_0000;
        if (cmd_valid_in) begin
            unique case (cmd_in.op)
                CMD_WRITE_BULK_PORT_ENABLES: begin
                    rsp_nxt.data = 32'h0000_0000;
                end
                CMD_READ_BULK_PORT_ENABLES: begin
                    rsp_nxt.data = {24'h00_0000, bulk_r};
                end
                CMD_READ_CHANNEL_STATE: begin
                    rsp_nxt.data = state_word(cmd_in.chan);
                end
                CMD_READ_CHANNEL_ERRORS: begin
                    rsp_nxt.data = error_word(cmd_in.chan);
                end
                CMD_CLEAR_CHANNEL_ERRORS: begin
                    rsp_nxt.data = 32'h0000_0000;
                end
                CMD_READ_UPSTREAM_SELECTION: begin
                    rsp_nxt.data = upstream_word();
                end
                CMD_READ_SUBSYSTEM_TEMPERATURE: begin
                    rsp_nxt.data = temp_micro_c_in;
                end
                default: begin
                    rsp_nxt.data = 32'h0000_0000;  // unused op codes
                end
            endcase
        end
    end

    // all registers of this module; the cycle timer counts and error flags sit in the per-channel instances
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bulk_r     <= BULK_RESET;
            rsp_r      <= '0;
            data_en_r  <= 4'h0;
            power_en_r <= 4'h0;
            overtemp_r <= 1'b0;
        end else begin
            bulk_r     <= bulk_nxt;
            rsp_r      <= rsp_nxt;
            data_en_r  <= data_en_nxt;
            power_en_r <= power_en_nxt;
            overtemp_r <= overtemp_nxt;     // live level, no clear reaches it
        end
    end

    assign rsp_out         = rsp_r;
    assign ch_data_en_out  = data_en_r;
    assign ch_power_en_out = power_en_r;

    // checks on the answers and enables
    a_bulk_reserved: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_valid_in && cmd_in.op == CMD_READ_BULK_PORT_ENABLES)
        |=> (rsp_out.valid && rsp_out.data[31:8] == 24'h00_0000))
        else $error("bulk read shows reserved bits");
    a_bulk_write_back: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_valid_in && cmd_in.op == CMD_WRITE_BULK_PORT_ENABLES)
        ##1 !is_write ##1 (cmd_valid_in && cmd_in.op == CMD_READ_BULK_PORT_ENABLES)
        |=> rsp_out.data == {24'h00_0000, $past(cmd_in.wdata[7:0], 3)})
        else $error("bulk read does not return last write");
    a_state_reserved: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_valid_in && cmd_in.op == CMD_READ_CHANNEL_STATE)
        |=> (rsp_out.data[18:2] == 17'h0_0000 && rsp_out.data[22:21] == 2'h0
             && rsp_out.data[31:25] == 7'h00))
        else $error("state read shows reserved bits");
    a_error_reserved: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_valid_in && cmd_in.op == CMD_READ_CHANNEL_ERRORS)
        |=> (rsp_out.data[2] == 1'b0 && rsp_out.data[31:4] == 28'h000_0000))
        else $error("error read shows reserved bits");
    a_state_power: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_valid_in && cmd_in.op == CMD_READ_CHANNEL_STATE)
        |=> rsp_out.data[0] == $past(ch_power_en_out[cmd_in.chan]))
        else $error("state power bit disagrees with switch");
    a_upstream_code: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_valid_in && cmd_in.op == CMD_READ_UPSTREAM_SELECTION
         && !up0_selected_in && !up1_selected_in)
        |=> rsp_out.data == 32'h0000_0002)
        else $error("no-upstream code wrong");
    a_overtemp_kept: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (hub_overtemp_in && is_clear) ##1 hub_overtemp_in ##1
        (cmd_valid_in && cmd_in.op == CMD_READ_CHANNEL_ERRORS)
        |=> rsp_out.data[3])
        else $error("overtemp flag lost on clear");
    a_upstream_port0: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_valid_in && cmd_in.op == CMD_READ_UPSTREAM_SELECTION && up0_selected_in)
        |=> rsp_out.data == UPSTREAM_PORT0)
        else $error("upstream port 0 code wrong");
    a_temp_pass: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_valid_in && cmd_in.op == CMD_READ_SUBSYSTEM_TEMPERATURE)
        |=> rsp_out.data == $past(temp_micro_c_in))
        else $error("temperature word not passed through");
    a_cc_shown: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_valid_in && cmd_in.op == CMD_READ_CHANNEL_STATE)
        |=> rsp_out.data[STATE_CC_BIT] == $past(ch_const_current_in[cmd_in.chan]))
        else $error("constant-current bit wrong");
    a_boost_shown: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (cmd_valid_in && cmd_in.op == CMD_READ_CHANNEL_STATE)
        |=> rsp_out.data[STATE_BOOST_BIT] == $past(boost_enabled_in))
        else $error("boost bit wrong");
endmodule
`default_nettype wire

// >>> sim/hpsc_host_model.sv
// host-side model: issues one command at a time and collects its answer
`timescale 1ns/100ps
`default_nettype none
module hpsc_host_model (
    input  wire logic                   ref_clk_in,    // bank clock
    input  wire hpsc_pkg::hpsc_rsp_type rsp_in,        // answer from the bank
    output logic                        cmd_valid_out, // request strobe
    output hpsc_pkg::hpsc_cmd_type      cmd_out        // request contents
);
    import hpsc_pkg::*;

    // idle until the bench asks for a transfer
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out       = '0;
    end

    // raise after an edge, hold through the taking edge, then wait a bounded time
    task automatic xfer(input hpsc_op_type op, input logic [1:0] chan,
                        input logic [31:0] wdata, output logic [31:0] rdata);
        int n;
        rdata = {32{1'bx}};  // stays unknown if no answer comes
        @(posedge ref_clk_in);
        cmd_valid_out <= 1'b1;
        cmd_out       <= '{op: op, chan: chan, wdata: wdata};
        @(posedge ref_clk_in);
        cmd_valid_out <= 1'b0;
        // no longer qualified: scramble so a late sample shows up
        cmd_out       <= '{op: hpsc_op_type'(~op), chan: ~chan, wdata: ~wdata};
        for (n = 0; n < 4; n++) begin
            #1;
            if (rsp_in.valid === 1'b1) begin
                rdata = rsp_in.data;
                break;
            end
            @(posedge ref_clk_in);
        end
    endtask
endmodule
`default_nettype wire

// >>> sim/hpsc_word_bank_tb.sv
// self-checking bench for the hub status and control word bank
`timescale 1ns/100ps
`default_nettype none
module hpsc_word_bank_tb;
    import hpsc_pkg::*;

    localparam int OFF_CYC = 8;   // shortened port-cycle off time

    logic         ref_clk;     // 25 MHz
    logic         rst_b;       // active-low reset
    logic         cmd_valid;   // from host model
    hpsc_cmd_type cmd;         // from host model
    hpsc_rsp_type rsp;         // answer
    logic         ready;       // always-accepting flag
    logic [3:0]   curlim, backdrive, trip, attached, cc;
    logic         boost, overtemp, up0, up1;
    logic [31:0]  temp;        // micro-degrees
    logic [3:0]   data_en, power_en;
    int           n_errors  = 0;
    int           tests_run = 0;

    // clock and time-zero input values
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        {curlim, backdrive, trip, attached, cc} = '0;
        {boost, overtemp, up0, up1} = 4'h0;
        temp = 32'h0;
    end
    always #20 ref_clk = ~ref_clk;

    hpsc_word_bank #(.CYCLE_OFF_CYCLES(OFF_CYC)) hpsc_word_bank_inst (
        .ref_clk_in(ref_clk), .rst_b_in(rst_b), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
        .cmd_ready_out(ready), .rsp_out(rsp), .ch_curlim_in(curlim),
        .ch_backdrive_in(backdrive), .ch_trip_in(trip), .ch_attached_in(attached),
        .ch_const_current_in(cc), .boost_enabled_in(boost), .hub_overtemp_in(overtemp),
        .up0_selected_in(up0), .up1_selected_in(up1), .temp_micro_c_in(temp),
        .ch_data_en_out(data_en), .ch_power_en_out(power_en));

    hpsc_host_model hpsc_host_model_inst (
        .ref_clk_in(ref_clk), .rsp_in(rsp), .cmd_valid_out(cmd_valid), .cmd_out(cmd));

    // single comparison point
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one command and a check of its answer word
    task automatic cmd_chk(input string what, input hpsc_op_type op, input logic [1:0] ch,
                           input logic [31:0] wd, input logic [31:0] exp);
        logic [31:0] d;
        hpsc_host_model_inst.xfer(op, ch, wd, d);
        check(what, d, exp);
    endtask

    // wait n edges, then let their updates land
    task automatic edges(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // expected channel state word
    function automatic logic [31:0] st(input logic p, d, e, b, a, c);
        st = 32'h0;
        st[STATE_PWR_BIT] = p;
        st[STATE_DATA_BIT] = d;
        st[STATE_ERR_BIT] = e;
        st[STATE_BOOST_BIT] = b;
        st[STATE_ATTACH_BIT] = a;
        st[STATE_CC_BIT] = c;
    endfunction

    // reset state, all channels up from the bulk reset value
    task automatic t_reset();
        edges(9);
        check("rsp in reset", {31'h0, rsp.valid}, 32'h0);
        check("power in reset", {28'h0, power_en}, 32'h0);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        edges(3);
        check("ready", {31'h0, ready}, 32'h1);
        check("data after reset", {28'h0, data_en}, 32'hF);
        check("power after reset", {28'h0, power_en}, 32'hF);
        cmd_chk("bulk reset", CMD_READ_BULK_PORT_ENABLES, 2'h0, 32'h0, 32'h0000_00FF);
    endtask

    // bulk write with reserved bits set, then per-channel state words
    task automatic t_bulk();
        int i;
        @(posedge ref_clk);
        boost <= 1'b1;
        attached <= 4'h5;
        cc <= 4'h8;
        cmd_chk("bulk wr ans", CMD_WRITE_BULK_PORT_ENABLES, 2'h0, 32'hFFFF_FF55, 32'h0);
        cmd_chk("bulk rd", CMD_READ_BULK_PORT_ENABLES, 2'h0, 32'h0, 32'h0000_0055);
        edges(2);
        check("data 55", {28'h0, data_en}, 32'hF);
        check("power 55", {28'h0, power_en}, 32'h0);
        for (i = 0; i < 4; i++) begin
            cmd_chk("state", CMD_READ_CHANNEL_STATE, 2'(i), 32'h0,
                    st(1'b0, 1'b1, 1'b0, 1'b1, attached[i], cc[i]));
        end
        cmd_chk("bulk wr AA", CMD_WRITE_BULK_PORT_ENABLES, 2'h0, 32'h0000_00AA, 32'h0);
        edges(2);
        check("data AA", {28'h0, data_en}, 32'h0);
        check("power AA", {28'h0, power_en}, 32'hF);
    endtask

    // data-only change with power on cycles that channel's power
    task automatic t_cycle();
        cmd_chk("bulk wr AB", CMD_WRITE_BULK_PORT_ENABLES, 2'h0, 32'h0000_00AB, 32'h0);
        edges(2);
        check("power cycling", {28'h0, power_en}, 32'hE);
        check("data AB", {28'h0, data_en}, 32'h1);
        edges(OFF_CYC + 4);
        check("power back", {28'h0, power_en}, 32'hF);
    endtask

    // error flags, trip-off, per-channel clear, global overtemp
    task automatic t_errors();
        int i;
        logic [31:0] ex [4];
        ex = '{32'h8, 32'h9, 32'hA, 32'h8};
        @(posedge ref_clk);
        overtemp <= 1'b1;
        curlim <= 4'h2;
        backdrive <= 4'h4;
        trip <= 4'h8;
        @(posedge ref_clk);
        {curlim, backdrive, trip} <= '0;
        edges(3);
        for (i = 0; i < 4; i++) begin
            cmd_chk("err word", CMD_READ_CHANNEL_ERRORS, 2'(i), 32'h0, ex[i]);
        end
        check("tripped power", {28'h0, power_en}, 32'h7);
        check("tripped data", {28'h0, data_en}, 32'h1);
        cmd_chk("state ch3", CMD_READ_CHANNEL_STATE, 2'h3, 32'h0,
                st(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1));
        cmd_chk("state ch1", CMD_READ_CHANNEL_STATE, 2'h1, 32'h0,
                st(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
        cmd_chk("clear ch1", CMD_CLEAR_CHANNEL_ERRORS, 2'h1, 32'h0, 32'h0);
        cmd_chk("err ch1 clr", CMD_READ_CHANNEL_ERRORS, 2'h1, 32'h0, 32'h8);
        cmd_chk("err ch2 kept", CMD_READ_CHANNEL_ERRORS, 2'h2, 32'h0, 32'hA);
        cmd_chk("clear ch3", CMD_CLEAR_CHANNEL_ERRORS, 2'h3, 32'h0, 32'h0);
        edges(3);
        check("power untripped", {28'h0, power_en}, 32'hF);
        @(posedge ref_clk);
        overtemp <= 1'b0;
        edges(2);
        cmd_chk("overtemp gone", CMD_READ_CHANNEL_ERRORS, 2'h0, 32'h0, 32'h0);
    endtask

    // upstream selection codes and temperature pass-through
    task automatic t_misc();
        int i;
        logic [31:0] ex [4];
        ex = '{UPSTREAM_NONE, UPSTREAM_PORT1, UPSTREAM_PORT0, UPSTREAM_PORT0};
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            {up0, up1} <= 2'(i);
            edges(2);
            cmd_chk("upstream", CMD_READ_UPSTREAM_SELECTION, 2'h0, 32'h0, ex[i]);
        end
        @(posedge ref_clk);
        temp <= 32'hFFFF_FC18;
        edges(2);
        cmd_chk("temperature", CMD_READ_SUBSYSTEM_TEMPERATURE, 2'h0, 32'h0, 32'hFFFF_FC18);
    endtask

    // counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        t_reset();
        t_bulk();
        t_cycle();
        t_errors();
        t_misc();
        print_verdict();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
